/* rtl/tscs_scheduler.sv */
// Compensation scheduler, frame timing and line control of the touch front end.
// Assumes sample, touch and measurement inputs come from logic on clk_sys.
`timescale 1ns/100ps
`default_nettype none

module tscs_scheduler #(
  parameter int DW           = 16,
  parameter int LED_FREQ_HZ  = 1000,
  parameter int FRAME_CYCLES = tscs_pkg::FRAME_MULT * (tscs_pkg::SENSE_CYCLES
                               + (tscs_pkg::CLK_HZ / LED_FREQ_HZ) * tscs_pkg::LED_STEPS)
) (
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire logic [7:0]           reg_addr,
  input  wire logic                 reg_wr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_rd,
  output logic      [7:0]           reg_rdata,
  input  wire logic                 sample_valid,
  input  wire logic [2:0]           sample_chan,
  input  wire logic signed [DW-1:0] sample_data,
  input  wire logic signed [DW-1:0] neg_limit,
  input  wire logic [7:0]           touch_in,
  input  wire logic                 meas_active,
  input  wire logic [2:0]           meas_line,
  output logic                      frame_tick,
  output logic                      measure_frame,
  output logic      [7:0]           comp_req,
  output logic      [7:0]           touch_valid,
  output logic      [7:0]           line_shield_en,
  output logic      [7:0]           line_gnd_en,
  output logic      [DW+2:0]        prox_sum,
  output logic                      analog_out_first,
  output logic                      analog_out_second
);

  localparam int NL = tscs_pkg::NUM_LINES;
  localparam int TW = tscs_pkg::TMR_W;
  localparam int SW = tscs_pkg::SKIP_W;

  // Stuck timeout in frames, zero meaning off
  function automatic logic [TW-1:0] stuck_limit(input logic [3:0] f);
    if (f[3]) begin
      stuck_limit = TW'(f[2:0] * tscs_pkg::STUCK_UNIT_L);
    end else if (f[2]) begin
      stuck_limit = TW'(f[1:0] * tscs_pkg::STUCK_UNIT_M);
    end else begin
      stuck_limit = TW'(f[1:0] * tscs_pkg::STUCK_UNIT_S);
    end
  endfunction

  // Number of lines with a pending request
  function automatic logic [3:0] count_ones(input logic [7:0] v);
    count_ones = 4'h0;
    for (int i = 0; i < NL; i++) begin
      count_ones = count_ones + 4'(v[i]);
    end
  endfunction

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [7:0] nf_q, nf_d, st_q, st_d, sk_q, sk_d, mc_q, mc_d;
  logic [7:0] pm_q, pm_d, rt_q, rt_d, rdata_q, rdata_d;

  // Byte writes and registered reads; reserved misc bits are dropped
  always_comb begin
    nf_d    = nf_q;
    st_d    = st_q;
    sk_d    = sk_q;
    mc_d    = mc_q;
    pm_d    = pm_q;
    rt_d    = rt_q;
    rdata_d = rdata_q;
    if (reg_wr) begin
      unique case (reg_addr)
        tscs_pkg::ADDR_NEG_FILT:  nf_d = reg_wdata;
        tscs_pkg::ADDR_STUCK:     st_d = reg_wdata;
        tscs_pkg::ADDR_SKIP:      sk_d = reg_wdata;
        tscs_pkg::ADDR_MISC:      mc_d = reg_wdata & tscs_pkg::MISC_WR_MASK;
        tscs_pkg::ADDR_PROX_MASK: pm_d = reg_wdata;
        tscs_pkg::ADDR_ROUTE:     rt_d = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        tscs_pkg::ADDR_NEG_FILT:  rdata_d = nf_q;
        tscs_pkg::ADDR_STUCK:     rdata_d = st_q;
        tscs_pkg::ADDR_SKIP:      rdata_d = sk_q;
        tscs_pkg::ADDR_MISC:      rdata_d = mc_q;
        tscs_pkg::ADDR_PROX_MASK: rdata_d = pm_q;
        tscs_pkg::ADDR_ROUTE:     rdata_d = rt_q;
        default:                  rdata_d = tscs_pkg::READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      nf_q    <= tscs_pkg::REG_RESET;
      st_q    <= tscs_pkg::REG_RESET;
      sk_q    <= tscs_pkg::REG_RESET;
      mc_q    <= tscs_pkg::REG_RESET;
      pm_q    <= tscs_pkg::REG_RESET;
      rt_q    <= tscs_pkg::REG_RESET;
      rdata_q <= tscs_pkg::REG_RESET;
    end else begin
      nf_q    <= nf_d;
      st_q    <= st_d;
      sk_q    <= sk_d;
      mc_q    <= mc_d;
      pm_q    <= pm_d;
      rt_q    <= rt_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------------------------------------------------------
  // Frame timing and frame skipping
  // ---------------------------------------------------------------
  logic [31:0]   fcnt_q, fcnt_d;
  logic [SW-1:0] skip_q, skip_d, skip_target;
  logic          tick_q, tick_d, meas_q, meas_d, wrap, sleep_on;

  // Frames keep their length whether or not they measure
  always_comb begin
    sleep_on = mc_q[tscs_pkg::MC_SLEEP];
    wrap     = (fcnt_q == 32'(FRAME_CYCLES - 1));
    fcnt_d   = wrap ? '0 : fcnt_q + 32'h1;
    if (sleep_on) begin
      skip_target = SW'(sk_q[tscs_pkg::SK_SLP_HI:tscs_pkg::SK_SLP_LO] * tscs_pkg::SLEEP_SKIP_MULT);
    end else begin
      skip_target = SW'(sk_q[tscs_pkg::SK_ACT_HI:tscs_pkg::SK_ACT_LO]);
    end
    tick_d = wrap;
    meas_d = wrap && (skip_q >= skip_target);
    skip_d = skip_q;
    if (wrap) begin
      skip_d = meas_d ? '0 : skip_q + SW'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fcnt_q <= '0;
      skip_q <= '0;
      tick_q <= 1'b0;
      meas_q <= 1'b0;
    end else begin
      fcnt_q <= fcnt_d;
      skip_q <= skip_d;
      tick_q <= tick_d;
      meas_q <= meas_d;
    end
  end

  assign frame_tick    = tick_q;
  assign measure_frame = meas_q;

  // ---------------------------------------------------------------
  // Negative averaging filter and drift debounce
  // ---------------------------------------------------------------
  logic signed [DW-1:0] avg_q [NL];
  logic signed [DW-1:0] avg_d [NL];
  logic        [3:0]    dcnt_q [NL];
  logic        [3:0]    dcnt_d [NL];
  logic        [7:0]    nreq_q, nreq_d;
  logic signed [DW-1:0] cur, newv;
  logic signed [DW:0]   diff, step;
  logic        [2:0]    coef;
  logic        [3:0]    need;

  // Drops below the average are smoothed, rises are taken directly
  always_comb begin
    avg_d  = avg_q;
    dcnt_d = dcnt_q;
    nreq_d = '0;
    coef   = nf_q[tscs_pkg::NF_COEF_HI:tscs_pkg::NF_COEF_LO];
    need   = 4'h1 << nf_q[tscs_pkg::NF_DEB_HI:tscs_pkg::NF_DEB_LO];
    cur    = avg_q[sample_chan];
    diff   = sample_data - cur;
    step   = diff >>> coef;
    newv   = sample_data;
    if (coef != 3'h0 && sample_data < cur) begin
      newv = cur + DW'(step);
    end
    if (sample_valid) begin
      avg_d[sample_chan] = newv;
      if (newv < neg_limit) begin
        if (dcnt_q[sample_chan] + 4'h1 >= need) begin
          nreq_d[sample_chan] = 1'b1;
          dcnt_d[sample_chan] = 4'h0;
        end else begin
          dcnt_d[sample_chan] = dcnt_q[sample_chan] + 4'h1;
        end
      end else begin
        dcnt_d[sample_chan] = 4'h0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int k = 0; k < NL; k++) begin
        avg_q[k]  <= '0;
        dcnt_q[k] <= 4'h0;
      end
      nreq_q <= '0;
    end else begin
      avg_q  <= avg_d;
      dcnt_q <= dcnt_d;
      nreq_q <= nreq_d;
    end
  end

  // ---------------------------------------------------------------
  // Stuck, periodic and grouped compensation
  // ---------------------------------------------------------------
  logic [TW-1:0] stk_q [NL];
  logic [TW-1:0] stk_d [NL];
  logic [TW-1:0] per_q, per_d, lim, per_lim;
  logic [7:0]    stuck_q, stuck_d, pend_q, pend_d, comp_q, comp_d, hit;
  logic [1:0]    grp;
  logic          per_hit;

  always_comb begin
    lim     = stuck_limit(st_q[tscs_pkg::ST_STK_HI:tscs_pkg::ST_STK_LO]);
    per_lim = TW'(st_q[tscs_pkg::ST_PER_HI:tscs_pkg::ST_PER_LO] * tscs_pkg::PERIODIC_UNIT);
    grp     = mc_q[tscs_pkg::MC_GRP_HI:tscs_pkg::MC_GRP_LO];
    stk_d   = stk_q;
    stuck_d = stuck_q;
    hit     = '0;
    for (int k = 0; k < NL; k++) begin
      if (!touch_in[k]) begin
        stk_d[k]   = '0;
        stuck_d[k] = 1'b0;
      end else if (comp_q[k]) begin
        stk_d[k] = '0;
      end else if (tick_q && !stuck_q[k] && lim != '0) begin
        if (stk_q[k] + TW'(1) >= lim) begin
          hit[k]     = 1'b1;
          stuck_d[k] = 1'b1;
          stk_d[k]   = '0;
        end else begin
          stk_d[k] = stk_q[k] + TW'(1);
        end
      end
    end
    per_hit = 1'b0;
    per_d   = per_q;
    if (per_lim == '0) begin
      per_d = '0;
    end else if (tick_q) begin
      per_hit = (per_q + TW'(1) >= per_lim);
      per_d   = per_hit ? '0 : per_q + TW'(1);
    end
    // With grouping on, requests wait here until the group threshold is reached or a periodic pulse fires
    pend_d = pend_q | nreq_q | hit;
    comp_d = '0;
    if (per_hit || (grp != 2'h0 && count_ones(pend_d) >= 4'(grp))) begin
      comp_d = '1;
      pend_d = '0;
    end else if (grp == 2'h0) begin
      comp_d = pend_d;
      pend_d = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int k = 0; k < NL; k++) begin
        stk_q[k] <= '0;
      end
      per_q   <= '0;
      stuck_q <= '0;
      pend_q  <= '0;
      comp_q  <= '0;
    end else begin
      stk_q   <= stk_d;
      per_q   <= per_d;
      stuck_q <= stuck_d;
      pend_q  <= pend_d;
      comp_q  <= comp_d;
    end
  end

  assign comp_req    = comp_q;
  assign touch_valid = touch_in & ~stuck_q;

  // ---------------------------------------------------------------
  // Idle line drive, combined proximity and output routing
  // ---------------------------------------------------------------
  logic [7:0]    shield_q, shield_d, gnd_q, gnd_d;
  logic [DW+2:0] prox_q, prox_d;
  logic          out1_q, out1_d, out2_q, out2_d;
  tscs_pkg::tscs_idle_e idle_mode;

  always_comb begin
    idle_mode = tscs_pkg::tscs_idle_e'(mc_q[tscs_pkg::MC_IDLE_HI:tscs_pkg::MC_IDLE_LO]);
    shield_d  = '0;
    gnd_d     = '0;
    prox_d    = '0;
    for (int k = 0; k < NL; k++) begin
      if (!(meas_active && meas_line == 3'(k))) begin
        unique case (idle_mode)
          tscs_pkg::IDLE_SHIELD_A,
          tscs_pkg::IDLE_SHIELD_B: shield_d[k] = 1'b1;
          tscs_pkg::IDLE_FLOAT:    ;
          tscs_pkg::IDLE_GROUND:   gnd_d[k] = 1'b1;
        endcase
      end
      if (pm_q[k]) begin
        prox_d = prox_d + (DW+3)'(avg_q[k]);
      end
    end
    out1_d = |(touch_valid & ~rt_q);
    out2_d = |(touch_valid & rt_q);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      shield_q <= '0;
      gnd_q    <= '0;
      prox_q   <= '0;
      out1_q   <= 1'b0;
      out2_q   <= 1'b0;
    end else begin
      shield_q <= shield_d;
      gnd_q    <= gnd_d;
      prox_q   <= prox_d;
      out1_q   <= out1_d;
      out2_q   <= out2_d;
    end
  end

  assign line_shield_en    = shield_q;
  assign line_gnd_en       = gnd_q;
  assign prox_sum          = prox_q;
  assign analog_out_first  = out1_q;
  assign analog_out_second = out2_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_measured;
    tick_q && meas_q;
  endsequence
  sequence s_all_fire;
    comp_q == 8'hFF;
  endsequence

  property p_deb_first;
    sample_valid && need == 4'h1 && newv < neg_limit |=> nreq_q != 8'h00;
  endproperty
  a_deb_first: assert property (p_deb_first) else $error("debounce off missed");
  property p_avg_bypass;
    sample_valid && coef == 3'h0 |=> avg_q[$past(sample_chan)] == $past(sample_data);
  endproperty
  a_avg_bypass: assert property (p_avg_bypass) else $error("bypass average");
  property p_stuck_off;
    lim == '0 && stuck_q == 8'h00 |=> stuck_q == 8'h00;
  endproperty
  a_stuck_off: assert property (p_stuck_off) else $error("stuck while off");
  property p_per_off;
    per_lim == '0 |=> per_q == '0 && comp_q != 8'hFF || $past(grp) != 2'h0;
  endproperty
  a_per_off: assert property (p_per_off) else $error("periodic while off");
  property p_skip;
    s_measured |-> skip_q == '0 ##1 (!meas_q)[*2];
  endproperty
  a_skip: assert property (p_skip) else $error("measure pulse");
  property p_sleep;
    sleep_on && sk_q[tscs_pkg::SK_SLP_HI:tscs_pkg::SK_SLP_LO] != 4'h0 && tick_q && !meas_q
      |-> skip_q <= skip_target && skip_q != '0;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep skip");
  property p_group;
    $past(grp) != 2'h0 && comp_q != 8'h00 |-> s_all_fire;
  endproperty
  a_group: assert property (p_group) else $error("partial group");
  property p_ground;
    idle_mode == tscs_pkg::IDLE_GROUND && !meas_active |=> gnd_q == 8'hFF && shield_q == 8'h00;
  endproperty
  a_ground: assert property (p_ground) else $error("ground mode");
  property p_route;
    touch_valid == 8'h01 && rt_q == 8'h00 |=> out1_q && !out2_q;
  endproperty
  a_route: assert property (p_route) else $error("routing");
  property p_release;
    !touch_in[0] |=> stk_q[0] == '0 && !stuck_q[0];
  endproperty
  a_release: assert property (p_release) else $error("stuck restart");

endmodule

`default_nettype wire

/* pkg/tscs_pkg.sv */
// Shared constants and types of the touch sense compensation scheduler.
// Assumes a 25 MHz system clock and a byte-wide register port on the same clock.
`default_nettype none

package tscs_pkg;

  // ---------------------------------------------------------------
  // Register offsets and reset value
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_NEG_FILT  = 8'h37;
  localparam logic [7:0] ADDR_STUCK     = 8'h38;
  localparam logic [7:0] ADDR_SKIP      = 8'h39;
  localparam logic [7:0] ADDR_MISC      = 8'h3A;
  localparam logic [7:0] ADDR_PROX_MASK = 8'h3B;
  localparam logic [7:0] ADDR_ROUTE     = 8'h3E;
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [7:0] MISC_WR_MASK   = 8'h3B;
  localparam logic [7:0] READ_UNMAPPED  = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int NF_DEB_HI  = 4;
  localparam int NF_DEB_LO  = 3;
  localparam int NF_COEF_HI = 2;
  localparam int NF_COEF_LO = 0;
  localparam int ST_STK_HI  = 7;
  localparam int ST_STK_LO  = 4;
  localparam int ST_PER_HI  = 3;
  localparam int ST_PER_LO  = 0;
  localparam int SK_ACT_HI  = 7;
  localparam int SK_ACT_LO  = 4;
  localparam int SK_SLP_HI  = 3;
  localparam int SK_SLP_LO  = 0;
  localparam int MC_GRP_HI  = 5;
  localparam int MC_GRP_LO  = 4;
  localparam int MC_SLEEP   = 3;
  localparam int MC_IDLE_HI = 1;
  localparam int MC_IDLE_LO = 0;

  // ---------------------------------------------------------------
  // Timing and scaling
  // ---------------------------------------------------------------
  localparam int NUM_LINES       = 8;
  localparam int CLK_HZ          = 25000000;
  localparam int CLK_PERIOD_NS   = 1000000000 / CLK_HZ;
  localparam int SENSE_TIME_NS   = 648000;
  localparam int SENSE_CYCLES    = SENSE_TIME_NS / CLK_PERIOD_NS;
  localparam int LED_STEPS       = 255;
  localparam int FRAME_MULT      = 9;
  localparam int STUCK_UNIT_S    = 64;
  localparam int STUCK_UNIT_M    = 128;
  localparam int STUCK_UNIT_L    = 256;
  localparam int PERIODIC_UNIT   = 128;
  localparam int SLEEP_SKIP_MULT = 4;
  localparam int SKIP_W          = 6;
  localparam int TMR_W           = 12;

  // Handling of lines that are not being measured
  typedef enum logic [1:0] {
    IDLE_SHIELD_A = 2'b00,
    IDLE_SHIELD_B = 2'b01,
    IDLE_FLOAT    = 2'b10,
    IDLE_GROUND   = 2'b11
  } tscs_idle_e;

endpackage

`default_nettype wire

/* bench/tscs_sense_model.sv */
// Model of the sense front end: sample pulses, touch levels, measured line.
// Assumes the bench calls its tasks at the falling edge of clk_sys.
`timescale 1ns/100ps
`default_nettype none

module tscs_sense_model #(
  parameter int DW = 16
) (
  input  wire logic                 clk_sys,
  output var  logic                 sample_valid,
  output var  logic [2:0]           sample_chan,
  output var  logic signed [DW-1:0] sample_data,
  output var  logic [7:0]           touch_in,
  output var  logic                 meas_active,
  output var  logic [2:0]           meas_line
);
  // --------------------------------------------------------------
  // Drivers
  // --------------------------------------------------------------
  // No samples and no touches at time zero, line 0 under measurement
  initial begin
    sample_valid = 1'b0;
    sample_chan  = 3'h0;
    sample_data  = '0;
    touch_in     = 8'h00;
    meas_active  = 1'b1;
    meas_line    = 3'h0;
  end

  // One sample pulse; data turns to garbage once the pulse is over
  task automatic send(input logic [2:0] ch, input logic signed [DW-1:0] d);
    @(negedge clk_sys);
    sample_valid = 1'b1;
    sample_chan  = ch;
    sample_data  = d;
    @(negedge clk_sys);
    sample_valid = 1'b0;
    sample_data  = ~d;
  endtask

  // Debounced touch levels
  task automatic set_touch(input logic [7:0] t);
    touch_in = t;
  endtask

  // Line under measurement
  task automatic set_meas(input logic a, input logic [2:0] l);
    meas_active = a;
    meas_line   = l;
  endtask
endmodule

`default_nettype wire

/* bench/test_touch_sense_compensation_scheduler.sv */
// Self-checking bench of the compensation scheduler, random and corner stimulus.
// Assumes the package, the scheduler and the sense model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module test_touch_sense_compensation_scheduler;
  localparam int FC    = 20;
  localparam int LIMIT = 30000;
  logic               clk_sys   = 1'b0;
  logic               reset     = 1'b1;
  logic [7:0]         reg_addr;
  logic               reg_wr;
  logic [7:0]         reg_wdata;
  logic               reg_rd;
  logic signed [15:0] neg_limit;
  logic [7:0]         reg_rdata, touch_in, comp_req, touch_valid, line_shield_en, line_gnd_en;
  logic               sample_valid, meas_active, frame_tick, measure_frame;
  logic [2:0]         sample_chan, meas_line;
  logic signed [15:0] sample_data;
  logic signed [18:0] prox_sum;
  logic               analog_out_first, analog_out_second;
  logic [7:0]         d, v, r, t, m;
  logic [7:0]         adr [6];
  int                 cyc, mlast, mgap, mcnt, tlast, tgap, flast, fgap, fcnt, ccnt, lsel;
  int                 err_count, checked, a, s, c, n, x;

  tscs_scheduler #(.DW(16), .FRAME_CYCLES(FC)) tscs_scheduler_inst (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_chan(sample_chan),
    .sample_data(sample_data), .neg_limit(neg_limit), .touch_in(touch_in), .meas_active(meas_active),
    .meas_line(meas_line), .frame_tick(frame_tick), .measure_frame(measure_frame), .comp_req(comp_req),
    .touch_valid(touch_valid), .line_shield_en(line_shield_en), .line_gnd_en(line_gnd_en),
    .prox_sum(prox_sum), .analog_out_first(analog_out_first), .analog_out_second(analog_out_second));

  tscs_sense_model #(.DW(16)) tscs_sense_model_inst (
    .clk_sys(clk_sys), .sample_valid(sample_valid), .sample_chan(sample_chan), .sample_data(sample_data),
    .touch_in(touch_in), .meas_active(meas_active), .meas_line(meas_line));

  // --------------------------------------------------------------
  // Clock, monitor and helpers
  // --------------------------------------------------------------
  // 25 MHz clock
  always #20 clk_sys = ~clk_sys;

  // Gaps between frame events, compensation pulse counts, hang guard
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (measure_frame === 1'b1) begin
      mgap = cyc - mlast;
      mlast = cyc;
      mcnt++;
    end
    if (frame_tick === 1'b1) begin
      tgap = cyc - tlast;
      tlast = cyc;
    end
    if (comp_req === 8'hFF) begin
      fgap = cyc - flast;
      flast = cyc;
      fcnt++;
    end
    if (comp_req !== 8'hFF && comp_req[lsel] === 1'b1) ccnt++;
    if (cyc == LIMIT) begin
      err_count++;
      print_verdict();
    end
  end

  // Verdict and end of run
  task automatic print_verdict();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Compare of wide values and counts
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Compare of byte results
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    chk_val({24'h000000, g}, {24'h000000, e});
  endtask

  task automatic tk(input int k);
    repeat (k) @(negedge clk_sys);
  endtask

  task automatic done(input string nm);
    $display("test %s done, err_count %0d", nm, err_count);
  endtask

  // Register write and read, one-cycle strobes
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(negedge clk_sys);
    reg_addr = ad;
    reg_wdata = dt;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
    @(negedge clk_sys);
    reg_addr = ad;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    dt = reg_rdata;
  endtask

  // Bounded wait for k more measured frames (f=0) or all-line compensation pulses (f=1)
  task automatic wait_cnt(input bit f, input int k);
    int s0;
    s0 = f ? fcnt : mcnt;
    for (int i = 0; i < 6000; i++) begin
      if ((f ? fcnt : mcnt) >= s0 + k) break;
      @(negedge clk_sys);
    end
  endtask

  // Average after one low sample with weight 1-1/2^k
  function automatic int exp_avg(input int av, input int sm, input int k);
    return av - ((av - sm) >>> k);
  endfunction

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
    neg_limit = 16'sh8000;
    n = $urandom(53058);
    adr = '{tscs_pkg::ADDR_NEG_FILT, 8'h38, 8'h39, 8'h3A, 8'h3B, 8'h3E};
    repeat (3) @(negedge clk_sys);
    reset = 1'b0;
    // Reset values, random read-back, reserved misc bits, unmapped place
    foreach (adr[i]) begin
      rd(adr[i], d);
      chk_reg(d, 8'h00);
      v = $urandom;
      wr(adr[i], v);
      rd(adr[i], d);
      chk_reg(d, (adr[i] == 8'h3A) ? (v & 8'h3B) : v);
      wr(adr[i], 8'h00);
    end
    wr(8'h3C, 8'hA5);
    rd(8'h3C, d);
    chk_reg(d, 8'h00);
    done("regs");
    // Idle line handling in every mode, with and without a measured line
    for (int i = 0; i < 8; i++) begin
      c = $urandom_range(7, 0);
      tscs_sense_model_inst.set_meas(i < 4, 3'(c));
      wr(8'h3A, 8'(i % 4));
      tk(2);
      v = (i < 4) ? ~(8'h01 << c) : 8'hFF;
      chk_reg(line_shield_en, (i % 4 < 2) ? v : 8'h00);
      chk_reg(line_gnd_en, (i % 4 == 3) ? v : 8'h00);
    end
    wr(8'h3A, 8'h00);
    done("idle");
    // Touch routing to the two analog outputs
    for (int i = 0; i < 6; i++) begin
      r = (i == 0) ? 8'h00 : $urandom;
      t = (i == 1) ? 8'h00 : (i == 0) ? 8'h01 : $urandom;
      wr(8'h3E, r);
      tscs_sense_model_inst.set_touch(t);
      tk(3);
      chk_val(analog_out_first, |(t & ~r));
      chk_val(analog_out_second, |(t & r));
    end
    tscs_sense_model_inst.set_touch(8'h00);
    done("route");
    // Combined proximity sum over masked lines
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? 8'hFF : $urandom;
      s = 0;
      wr(8'h3B, m);
      for (int k = 0; k < 8; k++) begin
        v = $urandom;
        tscs_sense_model_inst.send(3'(k), {4'h0, v, 4'h0});
        if (m[k]) s += v * 16;
      end
      tk(3);
      chk_val(prox_sum, s);
    end
    done("prox");
    // Negative averaging weight for every code
    wr(8'h3B, 8'h01);
    for (int k = 0; k < 8; k++) begin
      wr(8'h37, 8'h00);
      tscs_sense_model_inst.send(3'h0, 16'sh0A00);
      wr(8'h37, 8'(k));
      tscs_sense_model_inst.send(3'h0, 16'sh0000);
      tk(3);
      chk_val(prox_sum, exp_avg(2560, 0, k));
    end
    done("average");
    // Negative compensation debounce for every code
    c = $urandom_range(7, 0);
    lsel = c;
    neg_limit = 16'shFF9C;
    for (int dd = 0; dd < 4; dd++) begin
      wr(8'h37, 8'(dd << 3));
      tscs_sense_model_inst.send(3'(c), 16'sh0064);
      n = ccnt;
      for (int i = 1; i < (1 << dd); i++) tscs_sense_model_inst.send(3'(c), 16'shFF38);
      tk(3);
      chk_val(ccnt, n);
      tscs_sense_model_inst.send(3'(c), 16'shFF38);
      tk(3);
      chk_val(ccnt, n + 1);
    end
    done("debounce");
    // Group compensation once one, two or three lines ask
    lsel = 0;
    wr(8'h37, 8'h00);
    for (int g = 1; g < 4; g++) begin
      wr(8'h3A, 8'(g << 4));
      n = fcnt;
      x = ccnt;
      for (int k = 1; k < g; k++) tscs_sense_model_inst.send(3'(k), 16'shFF38);
      tk(4);
      chk_val(ccnt, x);
      chk_val(fcnt, n);
      tscs_sense_model_inst.send(3'h0, 16'shFF38);
      tk(4);
      chk_val(fcnt, n + 1);
    end
    wr(8'h3A, 8'h00);
    done("group");
    // Periodic compensation interval, then switched off
    wr(8'h38, 8'h01);
    wait_cnt(1'b1, 2);
    chk_val(fgap, 128 * FC);
    wr(8'h38, 8'h00);
    n = fcnt;
    tk(2700);
    chk_val(fcnt, n);
    done("periodic");
    // Stuck touch disqualified after 64, 128 and 256 frames, restarts on release
    lsel = 5;
    for (int i = 0; i < 3; i++) begin
      n = 64 << i;
      x = ccnt;
      wr(8'h38, 8'(8'h10 + i * 8'h40));
      tscs_sense_model_inst.set_touch(8'h20);
      tk((n - 2) * FC);
      chk_reg(touch_valid, 8'h20);
      tk(4 * FC);
      chk_reg(touch_valid, 8'h00);
      chk_val(ccnt, x + 1);
      tscs_sense_model_inst.set_touch(8'h00);
      tk(2);
      tscs_sense_model_inst.set_touch(8'h20);
      tk(2);
      chk_reg(touch_valid, 8'h20);
      tscs_sense_model_inst.set_touch(8'h00);
    end
    wr(8'h38, 8'h00);
    done("stuck");
    // Frame skipping in active and sleep mode
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 0 : $urandom_range(5, 0);
      s = (i == 0) ? 0 : $urandom_range(3, 0);
      wr(8'h39, 8'((a << 4) | s));
      wr(8'h3A, 8'h00);
      wait_cnt(1'b0, 2);
      chk_val(mgap, (a + 1) * FC);
      chk_val(tgap, FC);
      wr(8'h3A, 8'h08);
      wait_cnt(1'b0, 2);
      chk_val(mgap, (4 * s + 1) * FC);
    end
    done("skip");
    print_verdict();
  end
endmodule

`default_nettype wire
